// ---- logic/os_filter_defs.vh ----
`ifndef OS_FILTER_DEFS_VH
`define OS_FILTER_DEFS_VH

// converter and accumulator widths
`define SAMPLE_WIDTH      14
`define CHANNEL_COUNT     8
`define CHANNEL_BITS      3
`define MAX_SHIFT         6
`define ACC_WIDTH         20

// oversample ratio select codes
`define OSR_NONE          3'h0
`define OSR_INVALID       3'h7

// least time between two conversions at full rate, 200 kSPS
`define SAMPLE_PERIOD_NS  5000
`define CLOCK_PERIOD_NS   8
`define SAMPLE_PERIOD_CYC \
  ((`SAMPLE_PERIOD_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)

`endif

// ---- logic/acc_memory.v ----
`timescale 1ns/1ns
`include "os_filter_defs.vh"

module acc_memory #(
  parameter WIDTH = `ACC_WIDTH,
  parameter DEPTH = `CHANNEL_COUNT,
  parameter ABITS = `CHANNEL_BITS
) (
  input  wire             mclk,
  input  wire             clk_en,
  input  wire             wr_en,
  input  wire [ABITS-1:0] wr_addr,
  input  wire [WIDTH-1:0] wr_data,
  input  wire [ABITS-1:0] rd_addr,
  output reg  [WIDTH-1:0] rd_data
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];

  // one write port, registered read port
  always @(posedge mclk) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ---- logic/oversampling_average_filter.v ----
// Summary of operation
// - ratio codes 000 to 110 select ratios 1, 2, 4, 8, 16, 32 and 64.
// - throughput falls with the ratio, one full-rate period per sample set.
// - a run's first sample is taken on the rising edge of the start pins.
// - the other samples of a run are taken by an internal sampling strobe.
// - a run is averaged into exactly one 14-bit result per channel.
// - select high enables the band-gap and drives its level on the pin.
// - select low releases the reference pin as a high-impedance input.
// - the reference amplifier stays enabled in both reference modes.
// - every result is 14-bit two's complement.
`timescale 1ns/1ns
`include "os_filter_defs.vh"

module oversampling_average_filter #(
  parameter SAMPLE_CYC = `SAMPLE_PERIOD_CYC
) (
  input  wire                      mclk,
  input  wire                      rst_n,
  input  wire                      clk_en,
  input  wire                      conversion_start_a,
  input  wire                      conversion_start_b,
  input  wire [2:0]                oversample_ratio_select,
  input  wire                      reference_source_select,
  input  wire                      sample_valid,
  input  wire [`CHANNEL_BITS-1:0]  sample_channel,
  input  wire [`SAMPLE_WIDTH-1:0]  sample_data,
  output reg                       sample_strobe,
  output reg                       busy,
  output reg                       result_valid,
  output reg  [`CHANNEL_BITS-1:0]  result_channel,
  output reg  [`SAMPLE_WIDTH-1:0]  result_data,
  output reg                       bandgap_enable,
  output reg                       reference_io_pin_o,
  output reg                       reference_io_pin_oe,
  output wire                      reference_amp_enable
);

  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_CONV = 4'h2;
  localparam [3:0] S_GAP  = 4'h4;
  localparam [3:0] S_OUT  = 4'h8;
  localparam [31:0] TIMER_LOAD_W = SAMPLE_CYC - 1;
  localparam [15:0] TIMER_LOAD   = TIMER_LOAD_W[15:0];
  localparam [31:0] LAST_CH_W    = `CHANNEL_COUNT - 1;
  localparam [`CHANNEL_BITS-1:0] LAST_CH = LAST_CH_W[`CHANNEL_BITS-1:0];

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  reg [1:0] sta_sync_q;
  reg [1:0] stb_sync_q;
  reg [5:0] osr_sync_q;
  reg [1:0] ref_sync_q;
  reg       start_last_q;
  wire      start_lvl;
  wire      start_rise;

  // two flops on every pin before use
  always @(posedge mclk) begin
    if (!rst_n) begin
      sta_sync_q <= 2'h0;
      stb_sync_q <= 2'h0;
      osr_sync_q <= 6'h00;
      ref_sync_q <= 2'h0;
      start_last_q <= 1'b0;
    end else if (clk_en) begin
      sta_sync_q <= {sta_sync_q[0], conversion_start_a};
      stb_sync_q <= {stb_sync_q[0], conversion_start_b};
      osr_sync_q <= {osr_sync_q[2:0], oversample_ratio_select};
      ref_sync_q <= {ref_sync_q[0], reference_source_select};
      start_last_q <= start_lvl;
    end
  end

  // both start pins are one signal while oversampling
  assign start_lvl  = sta_sync_q[1] | stb_sync_q[1];
  assign start_rise = start_lvl & ~start_last_q;

  //////////////////////////////////////////////////////////////////////////
  // reference control

  // amplifier never powered down
  assign reference_amp_enable = 1'b1;

  // pin direction and level follow the synced select
  always @(posedge mclk) begin
    if (!rst_n) begin
      bandgap_enable      <= 1'b0;
      reference_io_pin_o  <= 1'b0;
      reference_io_pin_oe <= 1'b0;
    end else if (clk_en) begin
      bandgap_enable      <= ref_sync_q[1];
      reference_io_pin_o  <= ref_sync_q[1];
      reference_io_pin_oe <= ref_sync_q[1];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ratio decode

  reg [2:0] shift_d;

  // log2 of the ratio; 111 falls back to no averaging
  always @* begin
    case (osr_sync_q[5:3])
      `OSR_INVALID: shift_d = 3'h0;
      default:      shift_d = osr_sync_q[5:3];
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer

  reg [3:0]                state_q;
  reg [2:0]                shift_q;
  reg [5:0]                step_q;
  reg [5:0]                last_step_q;
  reg [`CHANNEL_BITS-1:0]  got_q;
  reg [15:0]               timer_q;
  reg [`CHANNEL_BITS-1:0]  out_ch_q;
  reg                      out_rd_q;
  reg [`CHANNEL_BITS-1:0]  out_rd_ch_q;
  reg                      wr_en_q;
  reg [`CHANNEL_BITS-1:0]  wr_ch_q;
  reg [`SAMPLE_WIDTH-1:0]  wr_smp_q;
  reg                      wr_first_q;
  wire [`ACC_WIDTH-1:0]    rd_data;
  wire [`ACC_WIDTH-1:0]    acc_sum;
  wire [`ACC_WIDTH-1:0]    acc_avg;
  wire [`CHANNEL_BITS-1:0] rd_addr;
  wire                     last_sample;

  assign last_sample = wr_en_q & (got_q == LAST_CH);
  assign rd_addr = (state_q == S_OUT) ? out_ch_q : sample_channel;

  // full-precision sum, sign extended sample
  assign acc_sum = (wr_first_q ? {`ACC_WIDTH{1'b0}} : rd_data) +
    {{(`ACC_WIDTH-`SAMPLE_WIDTH){wr_smp_q[`SAMPLE_WIDTH-1]}}, wr_smp_q};
  // divide by ratio with an arithmetic shift
  assign acc_avg = $signed(rd_data) >>> shift_q;

  // sample capture pipeline for read-modify-write
  always @(posedge mclk) begin
    if (!rst_n) begin
      wr_en_q    <= 1'b0;
      wr_ch_q    <= {`CHANNEL_BITS{1'b0}};
      wr_smp_q   <= {`SAMPLE_WIDTH{1'b0}};
      wr_first_q <= 1'b0;
    end else if (clk_en) begin
      wr_en_q    <= sample_valid & (state_q == S_CONV);
      wr_ch_q    <= sample_channel;
      wr_smp_q   <= sample_data;
      wr_first_q <= (step_q == 6'h00);
    end
  end

  // run control: start edge, internal strobes, readout
  always @(posedge mclk) begin
    if (!rst_n) begin
      state_q       <= S_IDLE;
      shift_q       <= 3'h0;
      step_q        <= 6'h00;
      last_step_q   <= 6'h00;
      got_q         <= {`CHANNEL_BITS{1'b0}};
      timer_q       <= 16'h0000;
      out_ch_q      <= {`CHANNEL_BITS{1'b0}};
      sample_strobe <= 1'b0;
      busy          <= 1'b0;
    end else if (clk_en) begin
      sample_strobe <= 1'b0;
      if (timer_q != 16'h0000) begin
        timer_q <= timer_q - 16'h0001;
      end
      if (wr_en_q) begin
        got_q <= got_q + 1'b1;
      end
      case (state_q)
        S_IDLE: begin
          if (start_rise && timer_q == 16'h0000) begin
            shift_q       <= shift_d;
            last_step_q   <= (6'h01 << shift_d) - 6'h01;
            step_q        <= 6'h00;
            got_q         <= {`CHANNEL_BITS{1'b0}};
            timer_q       <= TIMER_LOAD;
            sample_strobe <= 1'b1;
            busy          <= 1'b1;
            state_q       <= S_CONV;
          end
        end
        S_CONV: begin
          if (last_sample) begin
            if (step_q == last_step_q) begin
              out_ch_q <= {`CHANNEL_BITS{1'b0}};
              state_q  <= S_OUT;
            end else begin
              step_q  <= step_q + 6'h01;
              state_q <= S_GAP;
            end
          end
        end
        S_GAP: begin
          if (timer_q == 16'h0000) begin
            timer_q       <= TIMER_LOAD;
            sample_strobe <= 1'b1;
            got_q         <= {`CHANNEL_BITS{1'b0}};
            state_q       <= S_CONV;
          end
        end
        S_OUT: begin
          out_ch_q <= out_ch_q + 1'b1;
          if (out_ch_q == LAST_CH) begin
            busy    <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
          busy    <= 1'b0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // accumulator storage

  acc_memory #(
    .WIDTH (`ACC_WIDTH),
    .DEPTH (`CHANNEL_COUNT),
    .ABITS (`CHANNEL_BITS)
  ) u_acc (
    .mclk    (mclk),
    .clk_en  (clk_en),
    .wr_en   (wr_en_q),
    .wr_addr (wr_ch_q),
    .wr_data (acc_sum),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  //////////////////////////////////////////////////////////////////////////
  // decimated result output

  // one two's complement word per channel per run
  always @(posedge mclk) begin
    if (!rst_n) begin
      out_rd_q       <= 1'b0;
      out_rd_ch_q    <= {`CHANNEL_BITS{1'b0}};
      result_valid   <= 1'b0;
      result_channel <= {`CHANNEL_BITS{1'b0}};
      result_data    <= {`SAMPLE_WIDTH{1'b0}};
    end else if (clk_en) begin
      out_rd_q     <= (state_q == S_OUT);
      out_rd_ch_q  <= out_ch_q;
      result_valid <= out_rd_q;
      if (out_rd_q) begin
        result_channel <= out_rd_ch_q;
        result_data    <= acc_avg[`SAMPLE_WIDTH-1:0];
      end
    end
  end

endmodule

// ---- tb/osf_checker.sv ----
`timescale 1ns/1ns
module osf_checker #(
  parameter SAMPLE_CYC = 625
) (
  input wire       mclk,
  input wire       rst_n,
  input wire       conversion_start_a,
  input wire       conversion_start_b,
  input wire       reference_source_select,
  input wire       sample_strobe,
  input wire       busy,
  input wire       result_valid,
  input wire [2:0] result_channel,
  input wire       bandgap_enable,
  input wire       reference_io_pin_o,
  input wire       reference_io_pin_oe,
  input wire       reference_amp_enable
);
  reg [1:0]  rcnt_q;
  reg [15:0] gap_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////
  // cycles since reset release and since the last strobe
  always @(posedge mclk) begin
    if (!rst_n) begin
      rcnt_q <= 2'h0;
      gap_q  <= 16'hFFFF;
    end else begin
      if (rcnt_q != 2'h3) rcnt_q <= rcnt_q + 2'h1;
      if (sample_strobe) gap_q <= 16'h0000;
      else if (gap_q != 16'hFFFF) gap_q <= gap_q + 16'h0001;
    end
  end
  ////////////////////////////////////////////////////////////////////
  chk_amp_always_on: assert property (reference_amp_enable)
    else $error("reference amplifier disabled");
  chk_pin_follows_sel: assert property (rcnt_q == 2'h3 |->
    reference_io_pin_oe == $past(reference_source_select, 3))
    else $error("reference pin enable not following select");
  chk_pin_level_ok: assert property (reference_io_pin_o ==
    reference_io_pin_oe && bandgap_enable == reference_io_pin_oe)
    else $error("reference pin level or bandgap mismatch");
  chk_strobe_from_start: assert property (sample_strobe && !$past(busy)
    |-> $past(conversion_start_a | conversion_start_b, 3) &&
    !$past(conversion_start_a | conversion_start_b, 4))
    else $error("run started without start edge");
  chk_strobe_one_cycle: assert property (sample_strobe |=> !sample_strobe)
    else $error("strobe longer than one cycle");
  chk_strobe_in_run: assert property (sample_strobe |-> busy)
    else $error("strobe outside a run");
  chk_strobe_spacing: assert property (sample_strobe |->
    gap_q >= SAMPLE_CYC - 1)
    else $error("strobes closer than sample period");
  chk_first_result: assert property ($rose(result_valid)
    |-> result_channel == 3'h0)
    else $error("result burst not starting at channel 0");
  chk_result_order: assert property (result_valid && result_channel !=
    3'h7 |=> result_valid && result_channel == $past(result_channel) + 3'h1)
    else $error("result channels out of order");
endmodule
bind oversampling_average_filter osf_checker #(.SAMPLE_CYC(SAMPLE_CYC))
  i_osf_checker (.mclk, .rst_n, .conversion_start_a, .conversion_start_b,
  .reference_source_select, .sample_strobe, .busy, .result_valid,
  .result_channel, .bandgap_enable, .reference_io_pin_o,
  .reference_io_pin_oe, .reference_amp_enable);

// ---- tb/core_model.sv ----
`timescale 1ns/1ns
module core_model (
  input  wire        mclk,
  input  wire        busy,
  input  wire        sample_strobe,
  input  wire [13:0] base,
  output reg         sample_valid = 1'b0,
  output reg  [2:0]  sample_channel = 3'h0,
  output reg  [13:0] sample_data = 14'h0000
);
  reg        act_q = 1'b0;
  reg [2:0]  ch_q = 3'h0;
  reg [13:0] set_q = 14'h0000;
  ////////////////////////////////////////////////////////////////////
  // eight samples per strobe, value grows by one each set
  always @(posedge mclk) begin
    if (!busy) set_q <= 14'h0000;
    if (sample_strobe) act_q <= 1'b1;
    if (act_q) begin
      sample_valid   <= 1'b1;
      sample_channel <= ch_q;
      sample_data    <= base + {11'h000, ch_q} + set_q;
      ch_q           <= ch_q + 3'h1;
      if (ch_q == 3'h7) begin
        act_q <= 1'b0;
        set_q <= set_q + 14'h0001;
      end
    end else begin
      sample_valid <= 1'b0;
      sample_data  <= ~sample_data; // stale data never looks valid
    end
  end
endmodule

// ---- tb/oversampling_average_filter_tb.sv ----
`timescale 1ns/1ns
module oversampling_average_filter_tb;
  reg         mclk = 1'b0;
  reg         rst_n = 1'b0;
  reg         st = 1'b0;
  reg  [2:0]  osr = 3'h0;
  reg         ref_sel = 1'b0;
  reg  [13:0] base = 14'h0000;
  reg  [31:0] rng = 32'h00009C5B;
  wire        sample_valid, sample_strobe, busy, result_valid;
  wire [2:0]  sample_channel, result_channel;
  wire [13:0] sample_data, result_data;
  wire        bandgap_enable, pin_o, pin_oe, amp_en;
  integer     fail_count = 0;
  integer     check_count = 0;
  ////////////////////////////////////////////////////////////////////
  oversampling_average_filter #(.SAMPLE_CYC(40))
    i_oversampling_average_filter (
    .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1),
    .conversion_start_a(st), .conversion_start_b(st),
    .oversample_ratio_select(osr), .reference_source_select(ref_sel),
    .sample_valid(sample_valid), .sample_channel(sample_channel),
    .sample_data(sample_data), .sample_strobe(sample_strobe), .busy(busy),
    .result_valid(result_valid), .result_channel(result_channel),
    .result_data(result_data), .bandgap_enable(bandgap_enable),
    .reference_io_pin_o(pin_o), .reference_io_pin_oe(pin_oe),
    .reference_amp_enable(amp_en));
  core_model i_core_model (.mclk(mclk), .busy(busy),
    .sample_strobe(sample_strobe), .base(base), .sample_valid(sample_valid),
    .sample_channel(sample_channel), .sample_data(sample_data));
  ////////////////////////////////////////////////////////////////////
  function automatic [31:0] xs(input [31:0] s);
    begin
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      xs = s ^ (s << 5);
    end
  endfunction
  // floored mean of base+ch+set over the 2^c sets of a run
  function automatic [13:0] avg_exp(input [13:0] b, input [2:0] ch,
    input [2:0] c);
    begin
      avg_exp = b + {11'h000, ch} + (((14'h0001 << c) - 14'h0001) >> 1);
    end
  endfunction
  task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // one averaging run at ratio code c
  task run(input [2:0] c);
    integer i, t, n, s;
    logic [13:0] v, e;
    begin
      rng = xs(rng);
      v = {{3{rng[10]}}, rng[10:0]};
      n = 1 << c;
      @(posedge mclk);
      osr <= c;
      ref_sel <= rng[20];
      base <= v;
      repeat (4) @(posedge mclk);
      st <= 1'b1;
      i = 0;
      t = 0;
      s = 0;
      // watch from the first edge so the opening strobe is counted
      while (i < 8 && t < 5000) begin
        @(posedge mclk);
        if (t == 3) st <= 1'b0;
        #1;
        t = t + 1;
        if (sample_strobe === 1'b1) s = s + 1;
        if (result_valid === 1'b1) begin
          e = avg_exp(v, i[2:0], c);
          chk("channel", result_channel, i);
          chk("data", result_data, e);
          i = i + 1;
        end
      end
      chk("sets", s, n);
      chk("results", i, 8);
      chk("pin_oe", pin_oe, ref_sel);
      chk("pin_o", pin_o, ref_sel);
      chk("bandgap", bandgap_enable, ref_sel);
      chk("amp", amp_en, 1);
      repeat (45) @(posedge mclk);
      $display("test ratio code %0d done", c);
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 mclk = ~mclk;
  end
  initial begin
    repeat (40000) @(posedge mclk);
    fail_count = fail_count + 1;
    print_verdict;
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    for (int k = 0; k < 7; k++) run(k[2:0]);
    run(3'h6);
    run(3'h0);
    print_verdict;
  end
endmodule
